// ==== verilog/cbsc_buffer_ctrl.sv ====
// cbsc_buffer_ctrl: control word of one message buffer, shared by the
// processor and the protocol engine. assumes both sit on the controller
// clock, so none of their inputs needs a synchroniser.
//
// How it works
// - word holds length 15:12, reserved 11:8, rank 7:4, condition 3:0.
// - processor and engine both read and update the same storage.
// - engine may rewrite the condition; condition bit 0 is the busy flag.
// - while busy, only the low byte of the word accepts processor writes.
// - engine sets busy while copying a frame or sending from this buffer.
// - any engine condition update clears the busy flag.
// - bit 3 picks direction; receive idle codes are 0000, 0010, 0100, 0110.
// - frame copy turns armed, holding, overwritten into the matching busy code.
// - software writing receive idle mid-copy reads 0001 until copy ends.
// - send codes 1000, 1100, 1010, 1110; 1010 answers remote frames.
// - pending or sending shows the transmit code with busy set; a remote answer from 1010 shows 1111.
// - software writing send idle while sending reads 1001.
// - code 1011 is never produced.
// - single-then-remote becomes remote-only once its message is sent.
// - on reception the engine stores the received byte count.
// - length is a plain binary byte count from zero to eight.
// - no more than eight bytes move; codes from eight up mean eight.
// - bytes above the length are ignored on send, may be garbage on receive.
module cbsc_buffer_ctrl
	import cbsc_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESET_N_IN,
	// processor access to the control word and the buffer
	input  wire logic        CPU_WR_IN,
	input  wire logic [1:0]  CPU_BYTE_EN_IN,
	input  wire logic [15:0] CPU_WDATA_IN,
	input  wire logic        CPU_DATA_WR_IN,
	output logic      [15:0] CONTROL_WORD_OUT,
	output logic             DATA_WR_GRANT_OUT,
	// protocol engine events, one-cycle pulses
	input  wire logic        ENG_COND_WR_IN,
	input  wire logic [3:0]  ENG_COND_IN,
	input  wire logic        ENG_RX_COPY_START_IN,
	input  wire logic        ENG_RX_COPY_DONE_IN,
	input  wire logic [3:0]  ENG_RX_LEN_IN,
	input  wire logic        ENG_TX_START_IN,
	input  wire logic        ENG_TX_DONE_IN,
	input  wire logic        ENG_REMOTE_HIT_IN,
	// buffer status toward the engine
	output logic             BUSY_OUT,
	output logic             TX_READY_OUT,
	output logic             RX_ARMED_OUT,
	output logic             REMOTE_ANSWER_OUT,
	output logic      [3:0]  TX_RANK_OUT,
	output logic      [3:0]  TX_BYTE_COUNT_OUT,
	output logic      [7:0]  BYTE_VALID_OUT
);

	// reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// stored fields
	logic [3:0] cond;
	logic [3:0] rank;
	logic [3:0] len;
	cbsc_act_t  act;
	logic [3:0] next_rank;
	logic [3:0] next_len;

	// registered status views
	logic [15:0] word;
	logic        tx_ready;
	logic        rx_armed;
	logic        remote_ans;
	logic [15:0] next_word;
	logic        next_tx_ready;
	logic        next_rx_armed;
	logic        next_remote_ans;

	// processor write decode
	logic cpu_low_we;
	logic cpu_high_we;

	cbsc_core_if link ();

	always_comb begin
		cpu_low_we  = CPU_WR_IN & CPU_BYTE_EN_IN[0];
		// the high byte carries the length and is locked while busy
		cpu_high_we = CPU_WR_IN & CPU_BYTE_EN_IN[1] & ~cond[0];
	end

	// both parties feed the one shared condition register
	assign link.cond        = cond;
	assign link.act         = act;
	assign link.len         = len;
	assign link.cpu_cond_we = cpu_low_we;
	assign link.cpu_cond    = CPU_WDATA_IN[CBSC_COND_LSB +: CBSC_FIELD_W];
	assign link.eng_cond_we = ENG_COND_WR_IN;
	assign link.eng_cond    = ENG_COND_IN;
	assign link.rx_start    = ENG_RX_COPY_START_IN;
	assign link.rx_done     = ENG_RX_COPY_DONE_IN;
	assign link.tx_start    = ENG_TX_START_IN;
	assign link.tx_done     = ENG_TX_DONE_IN;
	assign link.remote_hit  = ENG_REMOTE_HIT_IN;
	assign link.data_wr     = CPU_DATA_WR_IN;

	cbsc_state_unit u_state (
		.link (link)
	);

	cbsc_access_gate u_gate (
		.clk_in    (REF_CLK_IN),
		.rst_n_in  (rst_n),
		.link      (link),
		.grant_out (DATA_WR_GRANT_OUT),
		.count_out (TX_BYTE_COUNT_OUT),
		.mask_out  (BYTE_VALID_OUT)
	);

	// rank and length fields
	always_comb begin
		next_rank = rank;
		next_len  = len;
		if (cpu_low_we) begin
			next_rank = CPU_WDATA_IN[CBSC_RANK_LSB +: CBSC_FIELD_W];
		end
		if (cpu_high_we) begin
			next_len = CPU_WDATA_IN[CBSC_LEN_LSB +: CBSC_FIELD_W];
		end
		// the engine's byte count wins over a write in the same cycle
		if (ENG_RX_COPY_DONE_IN && act == ACT_COPY && !ENG_COND_WR_IN) begin
			next_len = ENG_RX_LEN_IN;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cond <= CBSC_COND_RST;
			act  <= ACT_IDLE;
			rank <= CBSC_RANK_RST;
			len  <= CBSC_LEN_RST;
		end else begin
			cond <= link.next_cond;
			act  <= link.next_act;
			rank <= next_rank;
			len  <= next_len;
		end
	end

	// status views, registered from the next values so they track the word
	always_comb begin
		next_word = {next_len, CBSC_RSV_VAL, next_rank, link.next_cond};
		next_tx_ready = (link.next_cond == COND_TX_SINGLE)
			|| (link.next_cond == COND_TX_SINGLE_REMOTE);
		next_rx_armed = (link.next_cond == COND_RX_ARMED)
			|| (link.next_cond == COND_RX_HOLDING)
			|| (link.next_cond == COND_RX_OVERWRITTEN);
		next_remote_ans = (link.next_cond == COND_TX_REMOTE)
			|| (link.next_cond == COND_TX_SINGLE_REMOTE);
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			word       <= {CBSC_LEN_RST, CBSC_RSV_VAL, CBSC_RANK_RST, CBSC_COND_RST};
			tx_ready   <= 1'b0;
			rx_armed   <= 1'b0;
			remote_ans <= 1'b0;
		end else begin
			word       <= next_word;
			tx_ready   <= next_tx_ready;
			rx_armed   <= next_rx_armed;
			remote_ans <= next_remote_ans;
		end
	end

	// the read copy equals the stored fields in every cycle
	assign CONTROL_WORD_OUT  = word;
	assign BUSY_OUT          = word[CBSC_COND_LSB];
	assign TX_RANK_OUT       = word[CBSC_RANK_LSB +: CBSC_FIELD_W];
	assign TX_READY_OUT      = tx_ready;
	assign RX_ARMED_OUT      = rx_armed;
	assign REMOTE_ANSWER_OUT = remote_ans;

endmodule : cbsc_buffer_ctrl

// ==== common/cbsc_pkg.sv ====
// cbsc_pkg: field layout, condition codes, reset values and helpers of the
// buffer control word. assumes a single controller clock for every user.
package cbsc_pkg;

	localparam int CBSC_WORD_W  = 16;
	localparam int CBSC_FIELD_W = 4;

	// field positions inside the buffer control word
	localparam int CBSC_LEN_LSB  = 12;
	localparam int CBSC_RSV_LSB  = 8;
	localparam int CBSC_RANK_LSB = 4;
	localparam int CBSC_COND_LSB = 0;

	// values after reset
	localparam logic [3:0] CBSC_LEN_RST  = 4'h0;
	localparam logic [3:0] CBSC_RANK_RST = 4'h0;
	localparam logic [3:0] CBSC_COND_RST = 4'h0;
	localparam logic [3:0] CBSC_RSV_VAL  = 4'h0;

	// longest payload in bytes
	localparam logic [3:0] CBSC_LEN_MAX = 4'h8;

	// buffer condition codes, bit 3 is the direction, bit 0 the busy flag
	localparam logic [3:0] COND_RX_IDLE       = 4'h0;
	localparam logic [3:0] COND_RX_IDLE_BUSY  = 4'h1;
	localparam logic [3:0] COND_RX_ARMED      = 4'h2;
	localparam logic [3:0] COND_RX_COPY_FIRST = 4'h3;
	localparam logic [3:0] COND_RX_HOLDING    = 4'h4;
	localparam logic [3:0] COND_RX_COPY_SECOND = 4'h5;
	localparam logic [3:0] COND_RX_OVERWRITTEN = 4'h6;
	localparam logic [3:0] COND_RX_COPY_REPEAT = 4'h7;
	localparam logic [3:0] COND_TX_IDLE       = 4'h8;
	localparam logic [3:0] COND_TX_IDLE_BUSY  = 4'h9;
	localparam logic [3:0] COND_TX_REMOTE     = 4'ha;
	localparam logic [3:0] COND_TX_RESERVED   = 4'hb;
	localparam logic [3:0] COND_TX_SINGLE     = 4'hc;
	localparam logic [3:0] COND_TX_PEND_SINGLE = 4'hd;
	localparam logic [3:0] COND_TX_SINGLE_REMOTE = 4'he;
	localparam logic [3:0] COND_TX_PEND_REMOTE = 4'hf;

	// what the protocol engine is doing with this buffer
	typedef enum logic [1:0] {
		ACT_IDLE,
		ACT_COPY,
		ACT_SEND
	} cbsc_act_t;

	// payload length in bytes, codes above eight count as eight
	function automatic logic [3:0] cbsc_clamp_len(input logic [3:0] code);
		cbsc_clamp_len = (code >= CBSC_LEN_MAX) ? CBSC_LEN_MAX : code;
	endfunction : cbsc_clamp_len

	// the one transmit code that must never be shown is turned into the busy remote code
	function automatic logic [3:0] cbsc_fix_code(input logic [3:0] code);
		cbsc_fix_code = (code == COND_TX_RESERVED) ? COND_TX_PEND_REMOTE : code;
	endfunction : cbsc_fix_code

endpackage : cbsc_pkg

// ==== common/cbsc_core_if.sv ====
// cbsc_core_if: carries the buffer condition, the engine events and the
// length between the top and its two helpers. one clock domain throughout.
interface cbsc_core_if;
	import cbsc_pkg::*;

	logic [3:0] cond;
	cbsc_act_t  act;
	logic [3:0] len;
	logic       cpu_cond_we;
	logic [3:0] cpu_cond;
	logic       eng_cond_we;
	logic [3:0] eng_cond;
	logic       rx_start;
	logic       rx_done;
	logic       tx_start;
	logic       tx_done;
	logic       remote_hit;
	logic       data_wr;
	logic [3:0] next_cond;
	cbsc_act_t  next_act;

	modport core (
		output cond, act, len, cpu_cond_we, cpu_cond, eng_cond_we, eng_cond,
		output rx_start, rx_done, tx_start, tx_done, remote_hit, data_wr,
		input  next_cond, next_act
	);

	modport state (
		input  cond, act, cpu_cond_we, cpu_cond, eng_cond_we, eng_cond,
		input  rx_start, rx_done, tx_start, tx_done, remote_hit,
		output next_cond, next_act
	);

	modport gate (
		input cond, len, data_wr
	);

endinterface : cbsc_core_if

// ==== verilog/cbsc_state_unit.sv ====
// cbsc_state_unit: next buffer condition and engine activity from the
// processor write and the engine events. purely combinational; the top
// registers the result.
module cbsc_state_unit
	import cbsc_pkg::*;
(
	// shared state and events
	cbsc_core_if.state link
);

	logic [3:0] c;
	cbsc_act_t  a;

	always_comb begin
		c = link.cond;
		a = link.act;
		// processor write first, the engine then acts on its result
		if (link.cpu_cond_we) begin
			// busy stays set while the engine still owns the buffer
			c = cbsc_fix_code({link.cpu_cond[3:1], link.act != ACT_IDLE});
		end
		if (link.eng_cond_we) begin
			c = {link.eng_cond[3:1], 1'b0};
			a = ACT_IDLE;
		end else if (link.rx_done) begin
			if (a == ACT_COPY) begin
				a = ACT_IDLE;
				unique case (c[3:1])
					3'b001:         c = COND_RX_HOLDING;
					3'b010, 3'b011: c = COND_RX_OVERWRITTEN;
					default:        c = {c[3:1], 1'b0};
				endcase
			end
		end else if (link.tx_done) begin
			if (a == ACT_SEND) begin
				a = ACT_IDLE;
				unique case (c)
					COND_TX_PEND_SINGLE: c = COND_TX_IDLE;
					COND_TX_PEND_REMOTE: c = COND_TX_REMOTE;
					default:             c = cbsc_fix_code({c[3:1], 1'b0});
				endcase
			end
		end else if (link.rx_start) begin
			if (a == ACT_IDLE && (c == COND_RX_ARMED || c == COND_RX_HOLDING
					|| c == COND_RX_OVERWRITTEN)) begin
				c = {c[3:1], 1'b1};
				a = ACT_COPY;
			end
		end else if (link.tx_start) begin
			if (a == ACT_IDLE && (c == COND_TX_SINGLE || c == COND_TX_SINGLE_REMOTE)) begin
				c = {c[3:1], 1'b1};
				a = ACT_SEND;
			end
		end else if (link.remote_hit) begin
			// a remote answer from the remote-only code shows the busy remote code
			if (a == ACT_IDLE && (c == COND_TX_REMOTE || c == COND_TX_SINGLE_REMOTE)) begin
				c = COND_TX_PEND_REMOTE;
				a = ACT_SEND;
			end
		end
		link.next_cond = c;
		link.next_act  = a;
	end

endmodule : cbsc_state_unit

// ==== verilog/cbsc_access_gate.sv ====
// cbsc_access_gate: registered data write grant and payload length views.
// assumes the busy flag and length come from registers of the same clock.
module cbsc_access_gate
	import cbsc_pkg::*;
(
	// clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	// shared state
	cbsc_core_if.gate  link,
	// registered results
	output logic       grant_out,
	output logic [3:0] count_out,
	output logic [7:0] mask_out
);

	logic       next_grant;
	logic [3:0] next_count;
	logic [7:0] next_mask;

	always_comb begin
		next_grant = link.data_wr & ~link.cond[0];
		next_count = cbsc_clamp_len(link.len);
		// lanes above the count are don't-care for the engine
		next_mask  = 8'((9'h001 << next_count) - 9'h001);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			grant_out <= 1'b0;
			count_out <= CBSC_LEN_RST;
			mask_out  <= 8'h00;
		end else begin
			grant_out <= next_grant;
			count_out <= next_count;
			mask_out  <= next_mask;
		end
	end

endmodule : cbsc_access_gate

// ==== test/cbsc_buffer_ctrl_properties.sv ====
// cbsc_buffer_ctrl_props: port-level checks of one buffer control word.
// assumes engine pulses and processor writes follow the hand-over contract.
module cbsc_buffer_ctrl_props (
	// clock and reset
	input wire logic        REF_CLK_IN,
	input wire logic        RESET_N_IN,
	// watched ports
	input wire logic        CPU_WR_IN,
	input wire logic [1:0]  CPU_BYTE_EN_IN,
	input wire logic        CPU_DATA_WR_IN,
	input wire logic [15:0] CONTROL_WORD_OUT,
	input wire logic        DATA_WR_GRANT_OUT,
	input wire logic        ENG_COND_WR_IN,
	input wire logic [3:0]  ENG_COND_IN,
	input wire logic        ENG_RX_COPY_START_IN,
	input wire logic        ENG_RX_COPY_DONE_IN,
	input wire logic [3:0]  ENG_RX_LEN_IN,
	input wire logic        ENG_TX_DONE_IN,
	input wire logic        ENG_TX_START_IN,
	input wire logic        ENG_REMOTE_HIT_IN,
	input wire logic        BUSY_OUT,
	input wire logic [3:0]  TX_BYTE_COUNT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	logic [3:0] c;
	logic [3:0] l;
	assign c = CONTROL_WORD_OUT[3:0];
	assign l = CONTROL_WORD_OUT[15:12];

	a_rsv_read_zero: assert property (CONTROL_WORD_OUT[11:8] == 4'h0) else $error("reserved bits set");
	// only an engine start may hand the buffer to the engine; a processor write never sets busy
	a_busy_needs_start: assert property ($rose(BUSY_OUT)
		|-> $past(ENG_RX_COPY_START_IN || ENG_TX_START_IN || ENG_REMOTE_HIT_IN))
		else $error("busy set without start");
	a_no_rsv_code: assert property (c != 4'hb) else $error("reserved transmit code");
	a_grant_follows_busy: assert property (CPU_DATA_WR_IN |=> DATA_WR_GRANT_OUT == !$past(BUSY_OUT))
		else $error("data write grant wrong");
	a_high_byte_held: assert property (CPU_WR_IN && CPU_BYTE_EN_IN[1] && BUSY_OUT && !ENG_RX_COPY_DONE_IN
		|=> $stable(l)) else $error("length written while busy");
	a_eng_clears_busy: assert property (ENG_COND_WR_IN |=> !BUSY_OUT && c[3:1] == $past(ENG_COND_IN[3:1]))
		else $error("engine update kept busy");
	a_copy_sets_busy: assert property (ENG_RX_COPY_START_IN && !ENG_COND_WR_IN && !ENG_RX_COPY_DONE_IN
		&& !ENG_TX_DONE_IN && !CPU_WR_IN && c inside {4'h2, 4'h4, 4'h6} |=> c == ($past(c) | 4'h1))
		else $error("copy start code wrong");
	a_copy_done_hold: assert property (ENG_RX_COPY_DONE_IN && !ENG_COND_WR_IN && !CPU_WR_IN && c == 4'h3
		|=> c == 4'h4 && l == $past(ENG_RX_LEN_IN)) else $error("copy end wrong");
	a_sent_to_remote: assert property (ENG_TX_DONE_IN && c == 4'hf && !ENG_COND_WR_IN && !ENG_RX_COPY_DONE_IN
		&& !CPU_WR_IN |=> c == 4'ha) else $error("send end wrong");
	a_count_clamped: assert property (##1 TX_BYTE_COUNT_OUT == (($past(l) >= 4'h8) ? 4'h8 : $past(l)))
		else $error("byte count wrong");
	c_copy_repeat: cover property (c == 4'h7);
	c_send_idle_busy: cover property (c == 4'h9);
	c_grant: cover property (DATA_WR_GRANT_OUT);
endmodule : cbsc_buffer_ctrl_props

bind cbsc_buffer_ctrl cbsc_buffer_ctrl_props u_cbsc_buffer_ctrl_props (.REF_CLK_IN(REF_CLK_IN),
	.RESET_N_IN(RESET_N_IN), .CPU_WR_IN(CPU_WR_IN), .CPU_BYTE_EN_IN(CPU_BYTE_EN_IN),
	.CPU_DATA_WR_IN(CPU_DATA_WR_IN), .CONTROL_WORD_OUT(CONTROL_WORD_OUT), .DATA_WR_GRANT_OUT(DATA_WR_GRANT_OUT),
	.ENG_COND_WR_IN(ENG_COND_WR_IN), .ENG_COND_IN(ENG_COND_IN), .ENG_RX_COPY_START_IN(ENG_RX_COPY_START_IN),
	.ENG_RX_COPY_DONE_IN(ENG_RX_COPY_DONE_IN), .ENG_RX_LEN_IN(ENG_RX_LEN_IN), .ENG_TX_DONE_IN(ENG_TX_DONE_IN),
	.ENG_TX_START_IN(ENG_TX_START_IN), .ENG_REMOTE_HIT_IN(ENG_REMOTE_HIT_IN),
	.BUSY_OUT(BUSY_OUT), .TX_BYTE_COUNT_OUT(TX_BYTE_COUNT_OUT));

// ==== test/cbsc_eng_model.sv ====
// cbsc_eng_model: protocol engine side of one buffer, one-cycle event pulses.
// assumes the bench calls fire from its main thread, one event at a time.
module cbsc_eng_model (
	input  wire logic       clk_in,
	output logic      [5:0] ev_out,
	output logic      [3:0] val_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ev_out = 6'h00;
		val_out = 4'h0;
	end
	// value is only meaningful with its pulse; inverted afterwards so nothing leans on a stale one
	task automatic fire(input int b, input logic [3:0] v);
		@(posedge clk_in);
		ev_out[b] <= 1'b1;
		val_out <= v;
		@(posedge clk_in);
		ev_out <= 6'h00;
		val_out <= ~v;
	endtask : fire
endmodule : cbsc_eng_model

// ==== test/tb_top.sv ====
// tb_top: self-checking bench of the buffer control word.
// assumes the engine model drives every engine input of the block.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EW = 0, RS = 1, RD = 2, TS = 3, TD = 4, RH = 5;
	logic        REF_CLK_IN = 1'b0, RESET_N_IN = 1'b0, CPU_WR_IN = 1'b0, CPU_DATA_WR_IN = 1'b0;
	logic [1:0]  CPU_BYTE_EN_IN = 2'h0;
	logic [15:0] CPU_WDATA_IN = 16'h0000, CONTROL_WORD_OUT;
	logic        DATA_WR_GRANT_OUT, BUSY_OUT, TX_READY_OUT, RX_ARMED_OUT, REMOTE_ANSWER_OUT;
	logic [3:0]  TX_RANK_OUT, TX_BYTE_COUNT_OUT, val;
	logic [7:0]  BYTE_VALID_OUT;
	logic [5:0]  ev;
	int          failures = 0, n_tests = 0;
	always #4 REF_CLK_IN = ~REF_CLK_IN;
	cbsc_buffer_ctrl u_cbsc_buffer_ctrl (.REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .CPU_WR_IN(CPU_WR_IN),
		.CPU_BYTE_EN_IN(CPU_BYTE_EN_IN), .CPU_WDATA_IN(CPU_WDATA_IN), .CPU_DATA_WR_IN(CPU_DATA_WR_IN),
		.CONTROL_WORD_OUT(CONTROL_WORD_OUT), .DATA_WR_GRANT_OUT(DATA_WR_GRANT_OUT), .ENG_COND_WR_IN(ev[EW]),
		.ENG_COND_IN(val), .ENG_RX_COPY_START_IN(ev[RS]), .ENG_RX_COPY_DONE_IN(ev[RD]), .ENG_RX_LEN_IN(val),
		.ENG_TX_START_IN(ev[TS]), .ENG_TX_DONE_IN(ev[TD]), .ENG_REMOTE_HIT_IN(ev[RH]), .BUSY_OUT(BUSY_OUT),
		.TX_READY_OUT(TX_READY_OUT), .RX_ARMED_OUT(RX_ARMED_OUT), .REMOTE_ANSWER_OUT(REMOTE_ANSWER_OUT),
		.TX_RANK_OUT(TX_RANK_OUT), .TX_BYTE_COUNT_OUT(TX_BYTE_COUNT_OUT), .BYTE_VALID_OUT(BYTE_VALID_OUT));
	cbsc_eng_model u_cbsc_eng_model (.clk_in(REF_CLK_IN), .ev_out(ev), .val_out(val));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// the status flags are expected from the condition code alone, never from the block
	task automatic cw(input logic [15:0] exp);
		logic arm;
		logic rdy;
		logic rem;
		arm = exp[3:0] inside {4'h2, 4'h4, 4'h6};
		rdy = exp[3:0] inside {4'hc, 4'he};
		rem = exp[3:0] inside {4'ha, 4'he};
		#1 chk("control word", exp, CONTROL_WORD_OUT);
		chk("busy flag", {15'h0, exp[0]}, {15'h0, BUSY_OUT});
		chk("rx armed", {15'h0, arm}, {15'h0, RX_ARMED_OUT});
		chk("tx ready", {15'h0, rdy}, {15'h0, TX_READY_OUT});
		chk("remote answer", {15'h0, rem}, {15'h0, REMOTE_ANSWER_OUT});
	endtask : cw
	task automatic wr(input logic [1:0] be, input logic [15:0] d);
		@(posedge REF_CLK_IN);
		CPU_WR_IN <= 1'b1;
		CPU_BYTE_EN_IN <= be;
		CPU_WDATA_IN <= d;
		@(posedge REF_CLK_IN);
		CPU_WR_IN <= 1'b0;
		CPU_WDATA_IN <= ~d;
	endtask : wr
	task automatic dwr(input logic exp);
		@(posedge REF_CLK_IN);
		CPU_DATA_WR_IN <= 1'b1;
		@(posedge REF_CLK_IN);
		CPU_DATA_WR_IN <= 1'b0;
		#1 chk("grant", {15'h0, exp}, {15'h0, DATA_WR_GRANT_OUT});
	endtask : dwr
	task automatic t_reset();
		cw(16'h0000);
	endtask : t_reset
	task automatic t_rx();
		logic [3:0] st[3] = '{4'h3, 4'h5, 4'h7};
		logic [3:0] dn[3] = '{4'h4, 4'h6, 4'h6};
		wr(2'b01, 16'h0002); cw(16'h0002);
		u_cbsc_eng_model.fire(RS, 4'h0); cw(16'h0003);
		dwr(1'b0);
		wr(2'b10, 16'h9000); cw(16'h0003);
		wr(2'b01, 16'h0000); cw(16'h0001);
		u_cbsc_eng_model.fire(RD, 4'h5); cw(16'h5000);
		dwr(1'b1);
		wr(2'b01, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			u_cbsc_eng_model.fire(RS, 4'h0); cw({12'h500, st[i]});
			u_cbsc_eng_model.fire(RD, 4'h5); cw({12'h500, dn[i]});
		end
	endtask : t_rx
	task automatic t_tx();
		wr(2'b01, 16'h000e); cw(16'h500e);
		u_cbsc_eng_model.fire(TS, 4'h0); cw(16'h500f);
		u_cbsc_eng_model.fire(TD, 4'h0); cw(16'h500a);
		u_cbsc_eng_model.fire(RH, 4'h0); cw(16'h500f);
		wr(2'b01, 16'h0008); cw(16'h5009);
		u_cbsc_eng_model.fire(TD, 4'h0); cw(16'h5008);
		wr(2'b01, 16'h000c);
		u_cbsc_eng_model.fire(TS, 4'h0); cw(16'h500d);
		wr(2'b01, 16'h000a); cw(16'h500f);
		u_cbsc_eng_model.fire(EW, 4'h7); cw(16'h5006);
	endtask : t_tx
	task automatic t_len();
		logic [3:0] lens[4] = '{4'h0, 4'h3, 4'h8, 4'hc};
		logic [3:0] n;
		foreach (lens[i]) begin
			n = (lens[i] >= 4'h8) ? 4'h8 : lens[i];
			wr(2'b11, {lens[i], 12'hf90}); cw({lens[i], 12'h090});
			chk("rank", 16'h0009, {12'h0, TX_RANK_OUT});
			@(posedge REF_CLK_IN);
			#1 chk("byte count", {12'h0, n}, {12'h0, TX_BYTE_COUNT_OUT});
			chk("byte mask", 16'((1 << n) - 1), {8'h0, BYTE_VALID_OUT});
		end
	endtask : t_len
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20) @(posedge REF_CLK_IN);
		RESET_N_IN <= 1'b1;
		repeat (3) @(posedge REF_CLK_IN);
		t_reset();
		t_rx();
		t_tx();
		t_len();
		tally_and_finish();
	end
	// the tests need under a hundred cycles; 5000 leaves ample margin
	initial begin
		#40000;
		failures++;
		tally_and_finish();
	end
endmodule : tb_top
